// File: rtl/reset_sequencer.sv
// Reset sequencer with option straps, reset cause and watchdog
// Summary of operation
// - Watchdog option: always, halt in low power, off
// - Fast instruction cycle is 2/4/8/16 clocks
// - Slow mode cycle is low RC divided by four
// - Enabled reset pin low level resets system
// - Input option: no pull-up, pin reset disabled
// - Security option blocks full ROM read-out
// - Brownout threshold follows the level option
// - Indicator flags enabled per option, read-only
// - Any reset clears state, restarts at zero
// - Cause code 00 watchdog, 10 power, 11 pin
// - Power-up: stable, pin check, init, warm-up, run
// - Watchdog reset skips the pin check
// - After watchdog reset resume normal mode
// - Pin reset is level, low holds reset
// - Every brownout reset clears indicator flags
// - Indicator reads one at or below threshold
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
module reset_sequencer #(
  parameter logic [15:0] WARMUP_CYCLES = reset_seq_pkg::WARMUP_DEFAULT,
  parameter logic [15:0] WDT_CYCLES    = reset_seq_pkg::WDT_DEFAULT
) (
  input  wire logic                             clock_i,
  input  wire logic                             rst_n_i,
  input  wire logic [reset_seq_pkg::ADDR_W-1:0] address_i,
  input  wire logic                             read_i,
  input  wire logic                             write_i,
  input  wire logic [reset_seq_pkg::DATA_W-1:0] writedata_i,
  input  wire logic [3:0]                       byteenable_i,
  output logic [reset_seq_pkg::DATA_W-1:0]      readdata_o,
  output logic                                  waitrequest_o,
  input  wire logic                             reset_pin_i,
  input  wire logic                             supply_ok_i,
  input  wire logic                             below_24_i,
  input  wire logic                             below_36_i,
  input  wire logic                             lo_osc_i,
  input  wire logic [1:0]                       wdt_opt_i,
  input  wire logic [1:0]                       fcpu_opt_i,
  input  wire logic                             pin_opt_i,
  input  wire logic                             security_opt_i,
  input  wire logic [1:0]                       lvd_opt_i,
  input  wire logic                             powerdown_i,
  input  wire logic                             green_i,
  input  wire logic                             slow_mode_i,
  output logic                                  core_reset_n_o,
  output logic                                  cycle_en_o,
  output logic                                  mode_clear_o,
  output logic                                  pullup_en_o,
  output logic                                  general_input_pin_o,
  output logic                                  rom_dump_block_o,
  output logic                                  wdt_overflow_o
);
  import reset_seq_pkg::*;

  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic              lo_prev_q;
  logic              pin_s;
  logic              ok_s;
  logic              b24_s;
  logic              b36_s;
  logic [OPT_W-1:0]  strap_s;

  // Two-stage synchroniser for every asynchronous level
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_q   <= '0;
      sync2_q   <= '0;
      lo_prev_q <= 1'b0;
    end else begin
      sync1_q   <= {reset_pin_i, supply_ok_i, below_24_i, below_36_i,
                    lo_osc_i, wdt_opt_i, fcpu_opt_i, pin_opt_i,
                    security_opt_i, lvd_opt_i};
      sync2_q   <= sync1_q;
      lo_prev_q <= sync2_q[8];
    end
  end

  assign pin_s   = sync2_q[12];
  assign ok_s    = sync2_q[11];
  assign b24_s   = sync2_q[10];
  assign b36_s   = sync2_q[9];
  assign strap_s = sync2_q[7:0];

  cycle_if cyc ();

  cycle_divider u_div (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .cyc     (cyc)
  );

  seq_state_t       state_q;
  seq_state_t       state_d;
  logic [1:0]       cause_q;
  logic [1:0]       cause_d;
  logic [2:0]       alu_q;
  logic [2:0]       alu_d;
  logic             low_volt_mid_flag_q;
  logic             low_volt_mid_flag_d;
  logic             low_volt_high_flag_q;
  logic             low_volt_high_flag_d;
  logic [15:0]      warm_cnt_q;
  logic [15:0]      warm_cnt_d;
  logic [15:0]      wdt_cnt_q;
  logic [15:0]      wdt_cnt_d;
  logic [OPT_W-1:0] opt_q;
  logic [OPT_W-1:0] opt_d;
  logic             wdt_ovf_q;
  logic             wdt_ovf_d;
  logic             core_rst_n_q;
  logic             mode_clr_q;
  logic             pullup_q;
  logic             gpin_q;
  logic             rom_q;
  logic             wait_q;
  logic             wait_d;
  logic [31:0]      rdata_q;
  logic [31:0]      rdata_d;
  logic             lvd_trip;
  logic             pin_low;
  logic             wdt_run;
  logic             wdt_fire;
  logic             wr_take;
  logic             flags_wr;
  logic             wdt_clr;

  // Brownout trip for the chosen level
  function automatic logic lvd_trips(input logic [1:0] lvl,
                                     input logic ok, input logic b24,
                                     input logic b36);
    unique case (lvl)
      LVD_HIGH: lvd_trips = !ok || b24;
      LVD_TOP:  lvd_trips = !ok || b24 || b36;
      default:  lvd_trips = !ok;
    endcase
  endfunction

  assign lvd_trip = lvd_trips(opt_q[OPT_LVD_LSB +: 2], ok_s, b24_s,
                              b36_s);
  // Input option removes the pin from the reset path entirely
  assign pin_low  = (opt_q[OPT_PIN_BIT] == PIN_AS_RESET) && !pin_s;
  // Enable mode halts the count in power-down and green modes
  assign wdt_run  = (opt_q[OPT_WDT_LSB +: 2] == WDT_ALWAYS) ||
                    ((opt_q[OPT_WDT_LSB +: 2] == WDT_ENABLE) &&
                     !powerdown_i && !green_i);
  assign wdt_fire = wdt_run && (wdt_cnt_q == WDT_CYCLES - 16'h0001);
  assign wr_take  = write_i && !wait_q;
  assign flags_wr = wr_take && (address_i == FLAGS_ADDR) &&
                    byteenable_i[0];
  // Software must clear the count before it expires
  assign wdt_clr  = wr_take && (address_i == CTRL_ADDR) &&
                    byteenable_i[0] && writedata_i[WDT_CLR_BIT];

  always_comb begin
    state_d    = state_q;
    cause_d    = cause_q;
    alu_d      = alu_q;
    low_volt_mid_flag_d    = low_volt_mid_flag_q;
    low_volt_high_flag_d    = low_volt_high_flag_q;
    warm_cnt_d = warm_cnt_q;
    wdt_cnt_d  = wdt_cnt_q;
    opt_d      = opt_q;
    wdt_ovf_d  = 1'b0;
    unique case (state_q)
      ST_POWER_WAIT: begin
        // Straps are taken only while the supply settles
        opt_d   = strap_s;
        cause_d = CAUSE_POWER;
        low_volt_mid_flag_d = 1'b0;
        low_volt_high_flag_d = 1'b0;
        if (!lvd_trips(strap_s[OPT_LVD_LSB +: 2], ok_s, b24_s, b36_s)) begin
          state_d = (strap_s[OPT_PIN_BIT] == PIN_AS_RESET) ?
                    ST_PIN_CHECK : ST_INIT;
        end
      end
      ST_PIN_CHECK: begin
        if (lvd_trip) begin
          state_d = ST_POWER_WAIT;
          cause_d = CAUSE_POWER;
          {low_volt_mid_flag_d, low_volt_high_flag_d} = 2'b00;
        end else if (pin_s) begin
          state_d = ST_INIT;
        end
      end
      ST_INIT: begin
        alu_d      = ALU_RESET;
        warm_cnt_d = 16'h0000;
        wdt_cnt_d  = 16'h0000;
        state_d    = ST_WARMUP;
      end
      ST_WARMUP: begin
        if (lvd_trip) begin
          state_d = ST_POWER_WAIT;
          cause_d = CAUSE_POWER;
          {low_volt_mid_flag_d, low_volt_high_flag_d} = 2'b00;
        end else if (pin_low) begin
          state_d = ST_PIN_CHECK;
          cause_d = CAUSE_PIN;
        end else if (warm_cnt_q >= WARMUP_CYCLES - 16'h0001) begin
          state_d = ST_RUN;
        end else begin
          warm_cnt_d = warm_cnt_q + 16'h0001;
        end
      end
      ST_RUN: begin
        if (lvd_trip) begin
          state_d = ST_POWER_WAIT;
          cause_d = CAUSE_POWER;
          low_volt_mid_flag_d = 1'b0;
          low_volt_high_flag_d = 1'b0;
        end else if (pin_low) begin
          state_d = ST_PIN_CHECK;
          cause_d = CAUSE_PIN;
        end else if (wdt_fire) begin
          state_d   = ST_INIT;
          cause_d   = CAUSE_WDT;
          wdt_ovf_d = 1'b1;
        end else begin
          low_volt_mid_flag_d = b24_s && ((opt_q[OPT_LVD_LSB +: 2] == LVD_MID) ||
                    (opt_q[OPT_LVD_LSB +: 2] == LVD_HIGH));
          low_volt_high_flag_d = b36_s &&
                    (opt_q[OPT_LVD_LSB +: 2] == LVD_HIGH);
          if (wdt_clr) begin
            wdt_cnt_d = 16'h0000;
          end else if (wdt_run) begin
            wdt_cnt_d = wdt_cnt_q + 16'h0001;
          end
          if (flags_wr) begin
            cause_d = writedata_i[CAUSE_LSB +: 2];
            alu_d   = writedata_i[2:0];
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q      <= ST_POWER_WAIT;
      cause_q      <= CAUSE_POWER;
      alu_q        <= ALU_RESET;
      low_volt_mid_flag_q      <= 1'b0;
      low_volt_high_flag_q      <= 1'b0;
      warm_cnt_q   <= 16'h0000;
      wdt_cnt_q    <= 16'h0000;
      opt_q        <= OPT_RESET;
      wdt_ovf_q    <= 1'b0;
      core_rst_n_q <= 1'b0;
      mode_clr_q   <= 1'b1;
      pullup_q     <= 1'b0;
      gpin_q       <= 1'b0;
      rom_q        <= 1'b1;
    end else begin
      state_q      <= state_d;
      cause_q      <= cause_d;
      alu_q        <= alu_d;
      low_volt_mid_flag_q      <= low_volt_mid_flag_d;
      low_volt_high_flag_q      <= low_volt_high_flag_d;
      warm_cnt_q   <= warm_cnt_d;
      wdt_cnt_q    <= wdt_cnt_d;
      opt_q        <= opt_d;
      wdt_ovf_q    <= wdt_ovf_d;
      core_rst_n_q <= (state_d == ST_RUN);
      mode_clr_q   <= (state_d != ST_RUN);
      pullup_q     <= (opt_d[OPT_PIN_BIT] == PIN_AS_RESET);
      gpin_q       <= (opt_d[OPT_PIN_BIT] == PIN_AS_INPUT) && pin_s;
      rom_q        <= opt_d[OPT_SEC_BIT];
    end
  end

  assign cyc.fcpu_sel  = opt_q[OPT_FCPU_LSB +: 2];
  assign cyc.slow_mode = slow_mode_i;
  assign cyc.lo_rise   = sync2_q[8] && !lo_prev_q;
  assign cyc.run       = core_rst_n_q;

  // One wait state: data registered on the first cycle of a request
  always_comb begin
    wait_d  = 1'b1;
    rdata_d = rdata_q;
    if ((read_i || write_i) && wait_q) begin
      wait_d  = 1'b0;
      rdata_d = 32'h0000_0000;
      unique case (address_i)
        FLAGS_ADDR: rdata_d = {24'h00_0000, cause_q, low_volt_high_flag_q, low_volt_mid_flag_q,
                               1'b0, alu_q};
        STAT_ADDR:  rdata_d = {21'h00_0000, 3'(state_q), opt_q};
        default:    rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  assign readdata_o          = rdata_q;
  assign waitrequest_o       = wait_q;
  assign core_reset_n_o      = core_rst_n_q;
  assign cycle_en_o          = cyc.cycle_en;
  assign mode_clear_o        = mode_clr_q;
  assign pullup_en_o         = pullup_q;
  assign general_input_pin_o = gpin_q;
  assign rom_dump_block_o    = rom_q;
  assign wdt_overflow_o      = wdt_ovf_q;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  sequence run_wdt_fire;
    state_q == ST_RUN && !lvd_trip && !pin_low && wdt_fire;
  endsequence
  sequence wdt_restart;
    state_q == ST_INIT && cause_q == CAUSE_WDT ##1 state_q == ST_WARMUP;
  endsequence

  wdt_disabled_a: assert property (
    opt_q[OPT_WDT_LSB +: 2] == WDT_DISABLE |=> !wdt_overflow_o)
    else $error("watchdog reset while disabled");
  wdt_halt_a: assert property (
    state_q == ST_RUN && opt_q[OPT_WDT_LSB +: 2] == WDT_ENABLE &&
    (powerdown_i || green_i) && !wdt_clr && !lvd_trip && !pin_low
    |=> $stable(wdt_cnt_q))
    else $error("watchdog counted in low power mode");
  pin_reset_a: assert property (
    state_q == ST_RUN && !lvd_trip && pin_low
    |=> state_q == ST_PIN_CHECK && cause_q == CAUSE_PIN ##1 !core_reset_n_o)
    else $error("reset pin low did not reset");
  pin_held_a: assert property (
    state_q == ST_PIN_CHECK && !pin_s && !lvd_trip
    |=> state_q == ST_PIN_CHECK)
    else $error("released while reset pin low");
  input_mode_a: assert property (
    state_q == ST_PIN_CHECK |-> opt_q[OPT_PIN_BIT] == PIN_AS_RESET)
    else $error("pin check in general input mode");
  secure_rom_a: assert property (
    state_q == ST_RUN |-> rom_dump_block_o == opt_q[OPT_SEC_BIT])
    else $error("security option not applied");
  lvd_level_a: assert property (
    state_q == ST_RUN && opt_q[OPT_LVD_LSB +: 2] == LVD_HIGH && b24_s
    |=> state_q == ST_POWER_WAIT && cause_q == CAUSE_POWER)
    else $error("high level brownout missed");
  flag_enable_a: assert property (
    opt_q[OPT_LVD_LSB +: 2] == LVD_LOW || opt_q[OPT_LVD_LSB +: 2] == LVD_TOP
    |-> !low_volt_mid_flag_q && !low_volt_high_flag_q)
    else $error("indicator flag set while disabled");
  core_hold_a: assert property (
    state_q != ST_RUN |-> !core_reset_n_o)
    else $error("core released during reset sequence");
  wdt_cause_a: assert property (
    run_wdt_fire |=> wdt_restart)
    else $error("watchdog reset sequence wrong");
  normal_mode_a: assert property (
    wdt_overflow_o |-> mode_clear_o)
    else $error("low power mode kept after watchdog reset");
  init_order_a: assert property (
    state_q == ST_INIT |=> state_q == ST_WARMUP)
    else $error("init not followed by warm-up");
  lvd_clear_a: assert property (
    state_q == ST_POWER_WAIT |-> !low_volt_mid_flag_q && !low_volt_high_flag_q)
    else $error("indicator flags survive brownout");
  flag_live_a: assert property (
    state_q == ST_RUN && !lvd_trip && !pin_low && !wdt_fire &&
    opt_q[OPT_LVD_LSB +: 2] == LVD_MID |=> low_volt_mid_flag_q == $past(b24_s))
    else $error("indicator flag does not follow supply");

endmodule
`default_nettype wire

// File: rtl/reset_seq_pkg.sv
// Constants and types shared by the reset sequencer and its divider
package reset_seq_pkg;

  localparam int          ADDR_W          = 10;
  localparam int          DATA_W          = 32;

  // Register indices; the byte address is four times the index
  localparam logic [7:0]  FLAGS_IDX       = 8'h86;
  localparam logic [7:0]  CTRL_IDX        = 8'h90;
  localparam logic [7:0]  STAT_IDX        = 8'h91;
  localparam logic [9:0]  FLAGS_ADDR      = {FLAGS_IDX, 2'b00};
  localparam logic [9:0]  CTRL_ADDR       = {CTRL_IDX, 2'b00};
  localparam logic [9:0]  STAT_ADDR       = {STAT_IDX, 2'b00};

  // Flag and control register layout
  localparam int          CAUSE_LSB       = 6;
  localparam int          LOW_VOLT_HIGH_FLAG_BIT       = 5;
  localparam int          LOW_VOLT_MID_FLAG_BIT       = 4;
  localparam logic [2:0]  ALU_RESET       = 3'h0;
  localparam int          WDT_CLR_BIT     = 0;

  // Reset cause codes in bits 7:6
  localparam logic [1:0]  CAUSE_WDT       = 2'h0;
  localparam logic [1:0]  CAUSE_POWER     = 2'h2;
  localparam logic [1:0]  CAUSE_PIN       = 2'h3;

  // Option strap layout
  localparam int          OPT_W           = 8;
  localparam int          OPT_WDT_LSB     = 6;
  localparam int          OPT_FCPU_LSB    = 4;
  localparam int          OPT_PIN_BIT     = 3;
  localparam int          OPT_SEC_BIT     = 2;
  localparam int          OPT_LVD_LSB     = 0;
  localparam logic [7:0]  OPT_RESET       = 8'h00;

  localparam logic [1:0]  WDT_ALWAYS      = 2'h0;
  localparam logic [1:0]  WDT_ENABLE      = 2'h1;
  localparam logic [1:0]  WDT_DISABLE     = 2'h2;
  localparam logic        PIN_AS_RESET    = 1'b0;
  localparam logic        PIN_AS_INPUT    = 1'b1;
  localparam logic [1:0]  LVD_LOW         = 2'h0;
  localparam logic [1:0]  LVD_MID         = 2'h1;
  localparam logic [1:0]  LVD_HIGH        = 2'h2;
  localparam logic [1:0]  LVD_TOP         = 2'h3;

  // Cycle counts and synchroniser width
  localparam logic [15:0] WARMUP_DEFAULT  = 16'h0800;
  localparam logic [15:0] WDT_DEFAULT     = 16'h0fa0;
  localparam logic [1:0]  SLOW_LAST       = 2'h3;
  localparam int          SYNC_W          = 13;

  typedef enum logic [2:0] {
    ST_POWER_WAIT,
    ST_PIN_CHECK,
    ST_INIT,
    ST_WARMUP,
    ST_RUN
  } seq_state_t;

endpackage

// File: rtl/cycle_if.sv
// Link between the sequencer and the instruction-cycle divider
`timescale 1ns/10ps
`default_nettype none
interface cycle_if;
  logic [1:0] fcpu_sel;
  logic       slow_mode;
  logic       lo_rise;
  logic       run;
  logic       cycle_en;
  modport div (input fcpu_sel, slow_mode, lo_rise, run, output cycle_en);
  modport ctl (output fcpu_sel, slow_mode, lo_rise, run, input cycle_en);
endinterface
`default_nettype wire

// File: rtl/cycle_divider.sv
// Instruction-cycle enable divider, fast and slow clock modes
`timescale 1ns/10ps
`default_nettype none
module cycle_divider (
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  cycle_if.div      cyc
);
  import reset_seq_pkg::*;

  logic [3:0] hi_cnt_q;
  logic [3:0] hi_cnt_d;
  logic [1:0] lo_cnt_q;
  logic [1:0] lo_cnt_d;
  logic       en_q;
  logic       en_d;
  logic [3:0] hi_last;

  // Period is 2, 4, 8 or 16 fast clocks
  assign hi_last = 4'((5'h02 << cyc.fcpu_sel) - 5'h01);

  always_comb begin
    hi_cnt_d = hi_cnt_q;
    lo_cnt_d = lo_cnt_q;
    en_d     = 1'b0;
    if (!cyc.run) begin
      hi_cnt_d = 4'h0;
      lo_cnt_d = 2'h0;
    end else if (cyc.slow_mode) begin
      // Slow rate ignores the rate option
      hi_cnt_d = 4'h0;
      if (cyc.lo_rise) begin
        if (lo_cnt_q == SLOW_LAST) begin
          lo_cnt_d = 2'h0;
          en_d     = 1'b1;
        end else begin
          lo_cnt_d = lo_cnt_q + 2'h1;
        end
      end
    end else begin
      lo_cnt_d = 2'h0;
      if (hi_cnt_q >= hi_last) begin
        hi_cnt_d = 4'h0;
        en_d     = 1'b1;
      end else begin
        hi_cnt_d = hi_cnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hi_cnt_q <= 4'h0;
      lo_cnt_q <= 2'h0;
      en_q     <= 1'b0;
    end else begin
      hi_cnt_q <= hi_cnt_d;
      lo_cnt_q <= lo_cnt_d;
      en_q     <= en_d;
    end
  end

  assign cyc.cycle_en = en_q;

  fast_period_a: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    (cyc.run && !cyc.slow_mode && cyc.fcpu_sel == 2'h0 && en_q) ##1
    (cyc.run && !cyc.slow_mode && cyc.fcpu_sel == 2'h0)
    |-> !en_q ##1 en_q)
    else $error("fast cycle enable period wrong");

  slow_gate_a: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    (cyc.run && cyc.slow_mode && !cyc.lo_rise) |=> !en_q)
    else $error("slow cycle enable without slow clock edge");

endmodule
`default_nettype wire

// File: verification/core_model.sv
// Core-side model: low-power levels, cycle gap, overflow count
`timescale 1ns/10ps
`default_nettype none
module core_model (
  input  wire logic clock_i,
  input  wire logic cycle_en_i,
  input  wire logic mode_clear_i,
  input  wire logic want_pd_i,
  input  wire logic ovf_i,
  output var logic  powerdown_o = 1'b0,
  output var logic  green_o = 1'b0,
  output var int    gap_o = 0,
  output var int    n_ovf_o = 0
);
  int cnt = 0;
  always @(posedge clock_i) begin
    // Low power sticks until the sequencer clears the modes
    powerdown_o <= !mode_clear_i && (powerdown_o || want_pd_i);
    green_o     <= !mode_clear_i && (green_o || want_pd_i);
    cnt         <= cycle_en_i ? 1 : cnt + 1;
    if (cycle_en_i) gap_o <= cnt;
    if (ovf_i) n_ovf_o <= n_ovf_o + 1;
  end
endmodule
`default_nettype wire

// File: verification/mcu_reset_and_config_options_tb_top.sv
// Bench: power-up, cycle rate, flags, watchdog, pin and brownout runs
`timescale 1ns/10ps
`default_nettype none
module mcu_reset_and_config_options_tb_top;
  import reset_seq_pkg::*;
  logic        clock_i = 1'b0, rst_n_i = 1'b0, read_i = 1'b0;
  logic        write_i = 1'b0, reset_pin_i = 1'b0, supply_ok_i = 1'b0;
  logic        below_24_i = 1'b0, below_36_i = 1'b0, lo_osc_i = 1'b0;
  logic        pin_opt_i = 1'b0, security_opt_i = 1'b1;
  logic        slow_mode_i = 1'b0, want_pd = 1'b0;
  logic [1:0]  wdt_opt_i = WDT_ALWAYS, fcpu_opt_i = 2'h1;
  logic [1:0]  lvd_opt_i = LVD_HIGH;
  logic [3:0]  byteenable_i = 4'hf;
  logic [9:0]  address_i = 10'h000;
  logic [31:0] writedata_i = 32'h0, readdata_o, rd;
  logic        waitrequest_o, powerdown_i, green_i, core_reset_n_o;
  logic        cycle_en_o, mode_clear_o, pullup_en_o, general_input_pin_o;
  logic        rom_dump_block_o, wdt_overflow_o;
  int          n_fail = 0, n_compared = 0, cyc = 0, lo_cnt = 0;
  int          gap, n_ovf, k;

  reset_sequencer #(.WARMUP_CYCLES(16'h0004), .WDT_CYCLES(16'h0078)) dut (
    .clock_i, .rst_n_i, .address_i, .read_i, .write_i, .writedata_i,
    .byteenable_i, .readdata_o, .waitrequest_o, .reset_pin_i,
    .supply_ok_i, .below_24_i, .below_36_i, .lo_osc_i, .wdt_opt_i,
    .fcpu_opt_i, .pin_opt_i, .security_opt_i, .lvd_opt_i, .powerdown_i,
    .green_i, .slow_mode_i, .core_reset_n_o, .cycle_en_o, .mode_clear_o,
    .pullup_en_o, .general_input_pin_o, .rom_dump_block_o,
    .wdt_overflow_o);
  core_model core (.clock_i, .cycle_en_i(cycle_en_o),
    .mode_clear_i(mode_clear_o), .want_pd_i(want_pd),
    .ovf_i(wdt_overflow_o), .powerdown_o(powerdown_i),
    .green_o(green_i), .gap_o(gap), .n_ovf_o(n_ovf));

  initial begin
    forever #20 clock_i = ~clock_i;
  end
  // Slow oscillator: rising edge every 6 clocks
  always @(posedge clock_i) begin
    lo_cnt <= (lo_cnt == 2) ? 0 : lo_cnt + 1;
    if (lo_cnt == 2) lo_osc_i <= ~lo_osc_i;
  end
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_fail++;
      results();
    end
  end

  task automatic results;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [9:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    address_i <= a;
    writedata_i <= d;
    write_i <= wr;
    read_i <= !wr;
    do begin
      @(posedge clock_i);
      n++;
    end while (waitrequest_o !== 1'b0 && n < 50);
    rd = readdata_o;
    write_i <= 1'b0;
    read_i <= 1'b0;
    if (n >= 50) n_fail++;
    @(posedge clock_i);
  endtask
  task automatic rdc(input logic [9:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic kick;
    bus(1'b1, CTRL_ADDR, 32'h1);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic wait_run;
    int n;
    n = 0;
    while (core_reset_n_o !== 1'b1 && n < 300) begin
      @(posedge clock_i);
      n++;
    end
    if (n >= 300) n_fail++;
  endtask

  initial begin
    idle(10);
    rst_n_i <= 1'b1;
    idle(3);
    bus(1'b0, STAT_ADDR, 32'h0);
    chk(rd & 32'h700, 32'h000);
    supply_ok_i <= 1'b1;
    idle(6);
    bus(1'b0, STAT_ADDR, 32'h0);
    chk(rd & 32'h700, 32'h100);
    chk({31'h0, core_reset_n_o}, 32'h0);
    reset_pin_i <= 1'b1;
    wait_run();
    rdc(FLAGS_ADDR, 32'h80);
    rdc(STAT_ADDR, 32'h416);
    chk({30'h0, rom_dump_block_o, pullup_en_o}, 32'h3);
    rdc(10'h000, 32'h0);
    kick();
    idle(20);
    chk(gap, 32'd4);
    kick();
    slow_mode_i <= 1'b1;
    idle(35);
    kick();
    idle(35);
    chk(gap, 32'd24);
    slow_mode_i <= 1'b0;
    kick();
    below_36_i <= 1'b1;
    idle(6);
    rdc(FLAGS_ADDR, 32'ha0);
    bus(1'b1, FLAGS_ADDR, 32'hff);
    rdc(FLAGS_ADDR, 32'he7);
    // Brownout trip at the high level option
    below_24_i <= 1'b1;
    idle(6);
    rdc(STAT_ADDR, 32'h016);
    // Scratch bits are cleared only in the init step
    rdc(FLAGS_ADDR, 32'h87);
    below_24_i <= 1'b0;
    below_36_i <= 1'b0;
    wait_run();
    bus(1'b1, FLAGS_ADDR, 32'hc7);
    want_pd <= 1'b1;
    k = 0;
    while (n_ovf != 1 && k < 300) begin
      @(posedge clock_i);
      k++;
    end
    if (k >= 300) n_fail++;
    want_pd <= 1'b0;
    chk({30'h0, mode_clear_o, core_reset_n_o}, 32'h2);
    wait_run();
    chk({31'h0, powerdown_i}, 32'h0);
    rdc(FLAGS_ADDR, 32'h00);
    reset_pin_i <= 1'b0;
    idle(6);
    chk({31'h0, core_reset_n_o}, 32'h0);
    rdc(STAT_ADDR, 32'h116);
    reset_pin_i <= 1'b1;
    wait_run();
    rdc(FLAGS_ADDR, 32'hc0);
    reset_pin_i <= 1'b0;
    below_24_i <= 1'b1;
    idle(6);
    reset_pin_i <= 1'b1;
    below_24_i <= 1'b0;
    wait_run();
    rdc(FLAGS_ADDR, 32'h80);
    // Second power-up with the other strap settings
    rst_n_i <= 1'b0;
    {wdt_opt_i, fcpu_opt_i, pin_opt_i} <= {WDT_DISABLE, 2'h3, PIN_AS_INPUT};
    {security_opt_i, lvd_opt_i, reset_pin_i} <= {1'b0, LVD_MID, 1'b0};
    idle(10);
    rst_n_i <= 1'b1;
    wait_run();
    rdc(STAT_ADDR, 32'h4b9);
    chk({30'h0, rom_dump_block_o, pullup_en_o}, 32'h0);
    reset_pin_i <= 1'b1;
    idle(4);
    chk({31'h0, general_input_pin_o}, 32'h1);
    idle(40);
    chk(gap, 32'd16);
    {below_24_i, below_36_i} <= 2'b11;
    idle(6);
    rdc(FLAGS_ADDR, 32'h90);
    idle(150);
    chk(n_ovf, 32'd1);
    // Third power-up: enable-mode watchdog, fastest rate, top level
    rst_n_i <= 1'b0;
    {wdt_opt_i, fcpu_opt_i, lvd_opt_i} <= {WDT_ENABLE, 2'h0, LVD_TOP};
    {below_24_i, below_36_i} <= 2'b00;
    idle(10);
    rst_n_i <= 1'b1;
    wait_run();
    want_pd <= 1'b1;
    idle(20);
    chk(gap, 32'd2);
    idle(150);
    chk(n_ovf, 32'd1);
    want_pd <= 1'b0;
    below_36_i <= 1'b1;
    idle(6);
    rdc(STAT_ADDR, 32'h04b);
    below_36_i <= 1'b0;
    wait_run();
    idle(150);
    chk(n_ovf, 32'd2);
    results();
  end
endmodule
`default_nettype wire
